// ### verilog/txr_record_writer.v
// Writes information and time-tag words of transmit and mode records.
//
// Overview of operation
// (RL1) Host stores data, sets pointer, reserves first two record words.
// (RL2) Info word at pointer, time-tag at pointer+1, data from pointer+2.
// (RL3) Info and time-tag words are written only after message completion.
// (RL4) Host writes all transmit data before terminal starts transmitting.
// (RL5) Bit 13 set on bus activity where gap after command expected.
// (RL6) Bit 12 set when transmit command has unexpected data words.
// (RL7) Bit 10 set whenever gap or word count error arises.
// (RL8) Bit 9 set on busy answer from global or forced busy.
// (RL9) Bit 8 set when illegalization table entry is one.
// (RL10) Host keeps illegalization entries zero unless detection wanted.
// (RL11) Bit 6 set for error-free terminal-to-terminal transfer.
// (RL12) Bit 5 records bus: zero for A, one for B.
// (RL13) Bits 4..0 copy command word count; zero means thirty-two.
// (RL14) Mode codes 0..15 give two-word record, no data word.
// (RL15) Mode codes 16..31 store mode data word at pointer+2.
// (RL16) Unused bits 15, 14, 11 and 7 written as zero.
`timescale 1ns/10ps
`include "txr_regs.vh"
module txr_record_writer (
	clk,
	rst_n,
	cmd_start,
	cmd_ill_index,
	cmd_word_count,
	cmd_is_mode,
	data_ptr,
	bus_b,
	gap_seen,
	extra_words_seen,
	global_busy,
	force_busy_control,
	terminal_to_terminal_flag_ok,
	msg_done,
	time_tag,
	mode_data,
	ill_we,
	ill_waddr,
	ill_wdata,
	answer_busy,
	suppress_data,
	ram_we,
	ram_addr,
	ram_wdata,
	record_done,
	transmit_message_info_word
);
	input  wire        clk;
	input  wire        rst_n;
	input  wire        cmd_start;
	input  wire [11:0] cmd_ill_index;
	input  wire [4:0]  cmd_word_count;
	input  wire        cmd_is_mode;
	input  wire [15:0] data_ptr;
	input  wire        bus_b;
	input  wire        gap_seen;
	input  wire        extra_words_seen;
	input  wire        global_busy;
	input  wire        force_busy_control;
	input  wire        terminal_to_terminal_flag_ok;
	input  wire        msg_done;
	input  wire [15:0] time_tag;
	input  wire [15:0] mode_data;
	input  wire        ill_we;
	input  wire [11:0] ill_waddr;
	input  wire        ill_wdata;
	output wire        answer_busy;
	output wire        suppress_data;
	output reg         ram_we;
	output reg  [15:0] ram_addr;
	output reg  [15:0] ram_wdata;
	output wire        record_done;
	output wire [15:0] transmit_message_info_word;

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RUN  = 3'h1;
	localparam [2:0] ST_INFO = 3'h2;
	localparam [2:0] ST_TTAG = 3'h3;
	localparam [2:0] ST_DATA = 3'h4;
	localparam [2:0] ST_END  = 3'h5;

	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [15:0] ptr_reg;
	reg  [4:0]  wc_reg;
	reg         mode_reg;
	reg         bus_reg;
	reg         gap_reg;
	reg         wct_reg;
	reg         busy_reg;
	reg         terminal_to_terminal_flag_reg;
	reg  [15:0] info_reg;
	reg  [15:0] ttag_reg;
	reg         ill_reg;
	reg         ill_pend_reg;
	wire        ill_bit;
	wire [15:0] info_next;

	// Table lookup; index is sampled at command start, bit valid a cycle on.
	// The answer is latched then, since the index need not stay put later.
	txr_ill_mem u_ill (
		.clk   (clk),
		.we    (ill_we),
		.waddr (ill_waddr),
		.wdata (ill_wdata),
		.raddr (cmd_ill_index),
		.rdata (ill_bit)
	);

	// Busy answer stops data transmission for this command.
	assign answer_busy   = (state_reg == ST_RUN) & busy_reg; // see (RL8)
	assign suppress_data = answer_busy;
	assign record_done   = (state_reg == ST_END);
	assign transmit_message_info_word = info_reg;

	// Assemble the information word; unused bits stay zero.
	assign info_next = {2'b00,                         // see (RL16)
		gap_reg,                                   // see (RL5)
		wct_reg,                                   // see (RL6)
		1'b0,                                      // see (RL16)
		gap_reg | wct_reg,                         // see (RL7)
		busy_reg,                                  // see (RL8)
		ill_reg,                                   // see (RL9)
		1'b0,                                      // see (RL16)
		terminal_to_terminal_flag_reg & ~gap_reg & ~wct_reg,            // see (RL11)
		bus_reg,                                   // see (RL12)
		wc_reg};                                   // see (RL13)

	// Next-state logic: collect until completion, then write the record.
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (cmd_start) begin
				state_next = ST_RUN;
			end
		end
		ST_RUN: begin
			if (msg_done) begin
				state_next = ST_INFO; // see (RL3)
			end
		end
		ST_INFO: state_next = ST_TTAG;
		ST_TTAG: begin
			// Mode codes with data carry one word; others stop here.
			if (mode_reg && wc_reg[`TXR_MC_DATA_BIT]) begin
				state_next = ST_DATA; // see (RL15)
			end else begin
				state_next = ST_END; // see (RL14)
			end
		end
		ST_DATA: state_next = ST_END;
		ST_END:  state_next = ST_IDLE;
		default: state_next = ST_IDLE;
		endcase
	end

	// Capture command facts and error evidence while the message runs.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			ptr_reg   <= 16'h0000;
			wc_reg    <= 5'h00;
			mode_reg  <= 1'b0;
			bus_reg   <= 1'b0;
			gap_reg   <= 1'b0;
			wct_reg   <= 1'b0;
			busy_reg  <= 1'b0;
			terminal_to_terminal_flag_reg  <= 1'b0;
			info_reg  <= `TXR_INFO_RESET;
			ttag_reg  <= 16'h0000;
			ill_reg   <= 1'h0;
			ill_pend_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && cmd_start) begin
				ptr_reg  <= data_ptr; // see (RL2)
				wc_reg   <= cmd_word_count;
				mode_reg <= cmd_is_mode;
				bus_reg  <= bus_b;
				gap_reg  <= 1'b0;
				wct_reg  <= 1'b0;
				busy_reg <= global_busy | force_busy_control;
				terminal_to_terminal_flag_reg <= 1'b0;
				ill_pend_reg <= 1'h1;
			end else if (state_reg == ST_RUN) begin
				// Sticky error evidence; an event up to the msg_done cycle is kept, one after it is dropped.
				gap_reg  <= gap_reg | gap_seen;
				wct_reg  <= wct_reg | extra_words_seen;
				terminal_to_terminal_flag_reg <= terminal_to_terminal_flag_reg | terminal_to_terminal_flag_ok;
				// First running cycle: the table answer for the index
				// given with the command is on the read port now.
				if (ill_pend_reg) begin
					ill_reg      <= ill_bit; // see (RL9)
					ill_pend_reg <= 1'h0;
				end
				if (msg_done) begin
					ttag_reg <= time_tag;
				end
			end
			if (state_reg == ST_INFO) begin
				info_reg <= info_next;
			end
		end
	end

	// RAM write port: one word per cycle, record layout from pointer.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ram_we    <= 1'b0;
			ram_addr  <= 16'h0000;
			ram_wdata <= 16'h0000;
		end else begin
			ram_we <= 1'b0;
			case (state_reg)
			ST_INFO: begin
				ram_we    <= 1'b1;
				ram_addr  <= ptr_reg + `TXR_INFO_OFS; // see (RL2)
				ram_wdata <= info_next;
			end
			ST_TTAG: begin
				ram_we    <= 1'b1;
				ram_addr  <= ptr_reg + `TXR_TTAG_OFS; // see (RL2)
				ram_wdata <= ttag_reg;
			end
			ST_DATA: begin
				ram_we    <= 1'b1;
				ram_addr  <= ptr_reg + `TXR_DATA_OFS; // see (RL15)
				ram_wdata <= mode_data;
			end
			default: ram_we <= 1'b0;
			endcase
		end
	end
endmodule // txr_record_writer

// ### verilog/txr_regs.vh
// Constants for the transmit message record writer.
`ifndef TXR_REGS_VH
`define TXR_REGS_VH
`define TXR_INFO_OFS       16'h0000
`define TXR_TTAG_OFS       16'h0001
`define TXR_DATA_OFS       16'h0002
`define TXR_BIT_GAP        13
`define TXR_BIT_WCT        12
`define TXR_BIT_MESSAGE_FAULT_FLAG       10
`define TXR_BIT_BUSY       9
`define TXR_BIT_ILL        8
`define TXR_BIT_TERMINAL_TO_TERMINAL_FLAG       6
`define TXR_BIT_BUS        5
`define TXR_WC_MSB         4
`define TXR_MC_DATA_BIT    4
`define TXR_INFO_RESET     16'h0000
`define TXR_ILL_DEPTH      4096
`define TXR_ILL_AW         12
`endif

// ### verilog/txr_ill_mem.v
// Illegalization bit table, one bit per command combination, registered read.
`timescale 1ns/10ps
`include "txr_regs.vh"
module txr_ill_mem (
	clk,
	we,
	waddr,
	wdata,
	raddr,
	rdata
);
	input  wire        clk;
	input  wire        we;
	input  wire [11:0] waddr;
	input  wire        wdata;
	input  wire [11:0] raddr;
	output reg         rdata;

	reg mem [0:`TXR_ILL_DEPTH-1];

	// Read data comes out of a register so the lookup costs one cycle.
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // txr_ill_mem

// ### bench/txr_host_ram.sv
// Host side shared memory that keeps every record word the block writes.
`timescale 1ns/10ps
module txr_host_ram (
	input wire        clk,
	input wire        we,
	input wire [15:0] addr,
	input wire [15:0] wdata
);
	reg [15:0] mem [0:65535];
	// The bench preloads transmit data words here, as the host would.
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end
endmodule // txr_host_ram

// ### bench/txr_monitor.sv
// Checker of record write timing and info word layout.
`timescale 1ns/10ps
module txr_monitor (
	input wire        clk,
	input wire        rst_n,
	input wire        msg_done,
	input wire        ram_we,
	input wire [15:0] ram_addr,
	input wire [15:0] ram_wdata,
	input wire        record_done,
	input wire        answer_busy,
	input wire        suppress_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_info_timing: assert property (msg_done |-> ##2 ram_we)
		else $error("info write late");
	chk_early_write: assert property (ram_we |->
		$past(msg_done, 2) || $past(ram_we)) else $error("early write");
	chk_ttag_next: assert property (ram_we && $past(msg_done, 2) |=>
		ram_we && ram_addr == $past(ram_addr) + 16'h0001)
		else $error("time tag not at next word");
	chk_spare_zero: assert property (ram_we && $past(msg_done, 2) |->
		ram_wdata[15:14] == 2'h0 && !ram_wdata[11] && !ram_wdata[7])
		else $error("unused bits set");
	chk_message_fault_flag_cause: assert property (ram_we && $past(msg_done, 2) |->
		ram_wdata[10] == (ram_wdata[13] || ram_wdata[12]))
		else $error("message fault mismatch");
	chk_terminal_to_terminal_flag_clean: assert property (ram_we && $past(msg_done, 2) |->
		!(ram_wdata[6] && ram_wdata[10])) else $error("terminal_to_terminal_flag with fault");
	chk_busy_gate: assert property (answer_busy |->
		suppress_data && !ram_we && !record_done)
		else $error("busy without suppress");
	chk_done_bound: assert property (msg_done |-> ##[3:4] record_done)
		else $error("record not done");
	chk_busy_info: assert property (answer_busy && msg_done |->
		##2 ram_we && ram_wdata[9]) else $error("busy flag missing");
	chk_data_slot: assert property (ram_we && $past(ram_we) &&
		$past(ram_we, 2) |-> ram_addr == $past(ram_addr, 2) + 16'h0002)
		else $error("mode data not at third word");
endmodule // txr_monitor

bind txr_record_writer txr_monitor i_mon (.clk, .rst_n, .msg_done, .ram_we,
	.ram_addr, .ram_wdata, .record_done, .answer_busy, .suppress_data);

// ### bench/tb.sv
// Self-checking testbench for the transmit record writer.
`timescale 1ns/10ps
module tb;
	reg        clk = 1'h0, rst_n = 1'h0, cmd_start = 1'h0, cmd_is_mode = 1'h0;
	reg        bus_b = 1'h0, gap_seen = 1'h0, extra_words_seen = 1'h0;
	reg        global_busy = 1'h0, force_busy_control = 1'h0, terminal_to_terminal_flag_ok = 1'h0;
	reg        msg_done = 1'h0, ill_we = 1'h0, ill_wdata = 1'h0;
	reg [4:0]  cmd_word_count = 5'h00;
	reg [11:0] cmd_ill_index = 12'h000, ill_waddr = 12'h000;
	reg [15:0] data_ptr = 16'h0000, time_tag = 16'h0000, mode_data = 16'h0000;
	wire       ram_we, answer_busy, suppress_data, record_done;
	wire [15:0] ram_addr, ram_wdata, info_word;
	reg [15:0] exp_info;
	integer    n_mismatch = 0, total_checks = 0, i, k;
	// Free running clock, toggled every half period.
	always #10 clk = ~clk;
	txr_record_writer i_dut (.clk, .rst_n, .cmd_start, .cmd_ill_index,
		.cmd_word_count, .cmd_is_mode, .data_ptr, .bus_b, .gap_seen,
		.extra_words_seen, .global_busy, .force_busy_control, .terminal_to_terminal_flag_ok,
		.msg_done, .time_tag, .mode_data, .ill_we, .ill_waddr, .ill_wdata,
		.answer_busy, .suppress_data, .ram_we, .ram_addr, .ram_wdata,
		.record_done, .transmit_message_info_word(info_word));
	txr_host_ram i_ram (.clk, .we(ram_we), .addr(ram_addr), .wdata(ram_wdata));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	// One command; f is bus, gap, extra words, global busy, forced busy, terminal_to_terminal_flag.
	task run(input [15:0] p, input [4:0] wc, input m, input [5:0] f);
		begin
			i_ram.mem[p + 16'h0002] = 16'hBEEF;
			@(negedge clk);
			{data_ptr, cmd_ill_index, cmd_word_count, cmd_is_mode} = {p, p[11:0], wc, m};
			{time_tag, mode_data} = {~p, p ^ 16'h5A5A};
			{bus_b, global_busy, force_busy_control, cmd_start} = {f[5], f[2:1], 1'h1};
			@(negedge clk);
			{cmd_start, gap_seen, extra_words_seen, terminal_to_terminal_flag_ok} = {1'h0, f[4:3], f[0]};
			chk({15'h0000, answer_busy}, {15'h0000, |f[2:1]});
			chk({15'h0000, suppress_data}, {15'h0000, |f[2:1]});
			@(negedge clk);
			msg_done = 1'h1;
			@(negedge clk);
			{msg_done, gap_seen, extra_words_seen, terminal_to_terminal_flag_ok} = 4'h0;
			for (k = 0; k < 20 && record_done !== 1'h1; k = k + 1) @(negedge clk);
			chk({15'h0000, record_done}, 16'h0001);
			if (record_done !== 1'h1) end_sim;
			@(negedge clk);
			exp_info = {2'h0, f[4:3], 1'h0, |f[4:3], |f[2:1], p == 16'h0B00,
				1'h0, f[0] & ~|f[4:3], f[5], wc};
			chk(i_ram.mem[p], exp_info);
			chk(info_word, exp_info);
			chk(i_ram.mem[p + 16'h0001], ~p);
			chk(i_ram.mem[p + 16'h0002], m && wc[4] ? p ^ 16'h5A5A : 16'hBEEF);
			$display("test at %h done", p);
		end
	endtask
	// Clears the illegal table except one entry, then runs the commands.
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'h1;
		ill_we = 1'h1;
		for (i = 0; i < 4096; i = i + 1) begin
			{ill_waddr, ill_wdata} = {i[11:0], i[11:0] == 12'hB00};
			@(negedge clk);
		end
		ill_we = 1'h0;
		run(16'h0500, 5'h03, 1'h0, 6'h00);
		run(16'h0600, 5'h00, 1'h0, 6'h21);
		run(16'h0700, 5'h05, 1'h0, 6'h11);
		run(16'h0800, 5'h1F, 1'h0, 6'h0C);
		run(16'h0B00, 5'h02, 1'h0, 6'h02);
		run(16'h0C00, 5'h0F, 1'h1, 6'h00);
		run(16'h0D00, 5'h10, 1'h1, 6'h20);
		// A reset between records clears the held word and all strobes.
		rst_n = 1'h0;
		@(negedge clk);
		chk(info_word, 16'h0000);
		chk({13'h0000, ram_we, record_done, answer_busy}, 16'h0000);
		rst_n = 1'h1;
		run(16'h0500, 5'h03, 1'h0, 6'h00);
		end_sim;
	end
endmodule // tb
